// ### hdl/ipm_pkg.sv
// Shared constants, state type and strap decoding for the power monitor target interface.
// Assumes a single 200 MHz clock; all pin inputs already synchronous to it.
package ipm_pkg;
    // Clock and timing
    localparam int CLK_FREQ_MHZ = 200;
    localparam int CLK_PERIOD_NS = 5;
    localparam int CONV_TIME_MIN_US = 50;
    localparam int CONV_CYCLES_MIN = CONV_TIME_MIN_US * CLK_FREQ_MHZ;
    // Spike suppression widths, rounded down to whole cycles
    localparam int FS_SPIKE_NS = 50;
    localparam int HS_SPIKE_NS = 10;
    localparam int FS_FILT_CYCLES = FS_SPIKE_NS / CLK_PERIOD_NS;
    localparam int HS_FILT_CYCLES = HS_SPIKE_NS / CLK_PERIOD_NS;

    // Register pointer values
    localparam logic [7:0] PTR_BUS_VOLTAGE = 8'h05;
    localparam logic [7:0] PTR_DIE_TEMPERATURE = 8'h06;
    localparam logic [7:0] PTR_CURRENT = 8'h07;
    localparam logic [7:0] PTR_POWER = 8'h08;
    localparam logic [7:0] PTR_ENERGY = 8'h09;
    localparam logic [7:0] PTR_CHARGE = 8'h0a;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] WR_REG_COUNT = 8'h05;
    localparam logic [15:0] WR_REG_RESET = 16'h0000;
    localparam logic [3:0] TEMP_PAD = 4'h0;

    // Byte counts of a read
    localparam logic [2:0] LEN_WORD = 3'h2;
    localparam logic [2:0] LEN_POWER = 3'h3;
    localparam logic [2:0] LEN_ACC = 3'h5;

    // Bus addresses and codes
    localparam logic [6:0] ARA_ADDR = 7'h0c;
    localparam logic [4:0] HS_CODE_PREFIX = 5'h01;
    localparam logic [2:0] TARGET_ADDR_BASE = 3'h4;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [1:0] STRAP_GND = 2'h0;
    localparam logic [1:0] STRAP_VS = 2'h1;
    localparam logic [1:0] STRAP_SDA = 2'h2;
    localparam logic [1:0] STRAP_SCL = 2'h3;

    typedef enum {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_TX_NEXT, ST_WAIT
    } ipm_state_t;

    // Strap level at the start condition (SCL high, SDA low) and just after
    // the first SCL fall (SCL low, SDA still holding the address MSB of one)
    function automatic logic [1:0] strap_decode(input logic at_start, input logic after_fall);
        logic [1:0] code;
        case ({at_start, after_fall})
            2'b00: code = STRAP_GND;
            2'b11: code = STRAP_VS;
            2'b01: code = STRAP_SDA;
            default: code = STRAP_SCL;
        endcase
        return code;
    endfunction
endpackage

// ### hdl/ipm_line_if.sv
// Filtered bus levels and bus events passed from the line conditioner to the protocol engine.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface ipm_line_if;
    logic scl;
    logic sda;
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic hs_mode;
    modport cond (output scl, sda, start, stop, scl_rise, scl_fall, input hs_mode);
    modport fsm (input scl, sda, start, stop, scl_rise, scl_fall, output hs_mode);
endinterface
`default_nettype wire

// ### hdl/ipm_line_cond.sv
// Spike filter on SCL and SDA plus start, stop and clock edge detection.
// Assumes pin levels are synchronous to clk; filter width follows hs_mode.
`timescale 1ns/10ps
`default_nettype none
module ipm_line_cond
    import ipm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins
    input wire logic scl_pin,
    input wire logic sda_pin,
    // Events
    ipm_line_if.cond ln
);
    logic raw [2];
    logic filt [2];
    logic filt_d [2];
    logic [3:0] cnt [2];
    logic [3:0] limit;

    assign raw[0] = sda_pin;
    assign raw[1] = scl_pin;
    // Narrower filter in high-speed mode so 2.94 MHz edges pass
    assign limit = ln.hs_mode ? 4'(HS_FILT_CYCLES) : 4'(FS_FILT_CYCLES);

    generate
        for (genvar i = 0; i < 2; i++) begin : g_filt
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    cnt[i] <= 4'h0;
                    filt[i] <= 1'b1;
                    filt_d[i] <= 1'b1;
                end else begin
                    filt_d[i] <= filt[i];
                    if (raw[i] == filt[i]) begin
                        cnt[i] <= 4'h0;
                    end else if (cnt[i] >= limit - 4'h1) begin
                        cnt[i] <= 4'h0;
                        filt[i] <= raw[i];
                    end else begin
                        cnt[i] <= cnt[i] + 4'h1;
                    end
                end
            end
        end
    endgenerate

    assign ln.sda = filt[0];
    assign ln.scl = filt[1];
    assign ln.start = filt_d[1] & filt[1] & filt_d[0] & ~filt[0];
    assign ln.stop = filt_d[1] & filt[1] & ~filt_d[0] & filt[0];
    assign ln.scl_rise = ~filt_d[1] & filt[1];
    assign ln.scl_fall = filt_d[1] & ~filt[1];
endmodule
`default_nettype wire

// ### hdl/ipm_accum.sv
// Sample timer and the energy and charge accumulators.
// Assumes power and current inputs hold the latest conversion results.
`timescale 1ns/10ps
`default_nettype none
module ipm_accum
    import ipm_pkg::*;
#(
    parameter int CONV_CYCLES = CONV_CYCLES_MIN
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic [2:0] avg_sel,
    input wire logic acc_clear,
    // Results
    input wire logic [23:0] power,
    input wire logic [15:0] current,
    // Accumulators
    output logic [39:0] energy,
    output logic [39:0] charge,
    output logic charge_of,
    output logic sample_tick
);
    logic [31:0] period;
    logic [31:0] timer;
    logic [40:0] next_charge;
    logic charge_wrap;

    function automatic logic [10:0] avg_count(input logic [2:0] sel);
        logic [10:0] n;
        case (sel)
            3'h0: n = 11'h001;
            3'h1: n = 11'h004;
            3'h2: n = 11'h010;
            3'h3: n = 11'h040;
            3'h4: n = 11'h080;
            3'h5: n = 11'h100;
            3'h6: n = 11'h200;
            default: n = 11'h400;
        endcase
        return n;
    endfunction

    // Output period is conversion time times averaging count
    assign period = 32'(CONV_CYCLES) * {21'h000000, avg_count(avg_sel)}; // [R22]
    assign next_charge = {1'b0, charge} + {{25{current[15]}}, current};
    // Bit 40 is the carry of a positive sample and the borrow of a negative one
    assign charge_wrap = next_charge[40];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timer <= 32'h00000000;
            sample_tick <= 1'b0;
        end else if (timer >= period - 32'h1) begin
            timer <= 32'h00000000;
            sample_tick <= 1'b1;
        end else begin
            timer <= timer + 32'h1;
            sample_tick <= 1'b0;
        end
    end

    // Energy rolls over silently; the clear bit may zero it at any time
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            energy <= 40'h0000000000;
        end else if (acc_clear) begin
            energy <= 40'h0000000000; // [R20]
        end else if (sample_tick) begin
            energy <= energy + {16'h0000, power}; // [R20]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            charge <= 40'h0000000000;
        end else if (acc_clear) begin
            charge <= 40'h0000000000; // [R21]
        end else if (sample_tick) begin
            charge <= next_charge[39:0];
        end
    end

    // A wrap in the clearing cycle still raises the flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            charge_of <= 1'b0;
        end else if (sample_tick && charge_wrap) begin
            charge_of <= 1'b1; // [R21]
        end else if (acc_clear) begin
            charge_of <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### hdl/ipm_i2c_target.sv
// Top of the power monitor target interface: bus protocol, pointer, result map,
// alert response and high-speed mode. Assumes an external controller drives SCL
// and that SDA and the alert line are open drain with pull-ups outside.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// R1: First byte after a write address loads the register pointer.
// R2: Controller sends a pointer byte in every write, even pointer-only ones.
// R3: Acknowledge own target address; stay silent for other addresses.
// R4: Two bytes after the pointer go to the selected register, each acknowledged.
// R5: Reads return the register chosen by the last written pointer.
// R6: Read sends high byte, takes controller ack, then sends low byte.
// R7: Controller ends reads by nack, start or stop; device then releases SDA.
// R8: Reads never change the pointer; only writes do.
// R9: Data moves most significant byte first in both directions.
// R10: No clock stretching and no packet error checking bytes.
// R11: High-speed master code is not acknowledged but switches filters to fast mode.
// R12: Repeated starts keep high-speed mode; a stop returns to standard filters.
// R13: With a pending alert, acknowledge alert response read and send own address.
// R14: Losing arbitration in alert reply: no further drive, keep alert line low.
// R15: Current at 7h, bus voltage at 5h, 12-bit temperature at 6h.
// R16: Power 24-bit at 8h; energy and charge 40-bit at 9h and Ah.
// R17: Signed results are two's complement.
// R18: Results carry 2.4 mA, 3.125 mV and 125 m-degree steps per code.
// R19: Temperature code spans plus and minus 256; voltage code reaches 102.4 V.
// R20: Energy wraps to zero on overflow; clear bit zeroes it anytime.
// R21: Charge overflow sets its flag; clear bit resets the accumulator.
// R22: Shortest conversion 50 us; sample period is conversion times averaging.
// R23: Address straps sampled each transfer, giving addresses 1000000 to 1001111.
// R24: Wide results read as three or five bytes; narrow ones padded to 16 bits.
module ipm_i2c_target
    import ipm_pkg::*;
#(
    parameter int CONV_CYCLES = CONV_CYCLES_MIN
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Serial bus
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_N,
    // Address straps
    input wire logic ADDRESS_STRAP_LOW,
    input wire logic ADDRESS_STRAP_HIGH,
    // Alert line
    input wire logic ALERT_ACTIVE,
    output logic ALERT_OUT,
    output logic ALERT_OE_N,
    // Measurement results
    input wire logic [15:0] BUS_VOLTAGE,
    input wire logic [11:0] DIE_TEMPERATURE,
    input wire logic [15:0] CURRENT,
    input wire logic [23:0] POWER,
    // Accumulator control and status
    input wire logic [2:0] AVG_SEL,
    input wire logic ACCUMULATOR_CLEAR_BIT,
    output logic CHARGE_OVERFLOW_FLAG,
    output logic SAMPLE_TICK,
    output logic HS_MODE
);
    ipm_line_if ln ();
    ipm_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic [1:0] rx_idx;
    logic [2:0] tx_idx;
    logic is_read;
    logic in_ara;
    logic sda_oe_n;
    logic hs_mode;
    logic [7:0] pointer;
    logic [7:0] hi_byte;
    logic [15:0] wr_regs [5];
    logic [39:0] rd_data;
    logic [2:0] rd_len;
    logic [39:0] sel_data;
    logic [2:0] sel_len;
    logic [39:0] energy;
    logic [39:0] charge;
    logic [6:0] own_addr;
    logic strap_low_start;
    logic strap_high_start;
    logic first_fall;
    logic alert_d;
    logic alert_pending;
    logic addr_done;
    logic rx_done;
    logic own_match;
    logic ara_match;
    logic hs_code;
    logic ara_won;
    logic [7:0] tx_next;

    ipm_line_cond u_cond (
        .clk(CLK),
        .rst(RST),
        .scl_pin(SCL_IN),
        .sda_pin(SDA_IN),
        .ln(ln)
    );

    ipm_accum #(
        .CONV_CYCLES(CONV_CYCLES)
    ) u_accum (
        .clk(CLK),
        .rst(RST),
        .avg_sel(AVG_SEL),
        .acc_clear(ACCUMULATOR_CLEAR_BIT),
        .power(POWER),
        .current(CURRENT),
        .energy(energy),
        .charge(charge),
        .charge_of(CHARGE_OVERFLOW_FLAG),
        .sample_tick(SAMPLE_TICK)
    );

    assign ln.hs_mode = hs_mode;

    // Picks byte idx of a len-byte value, most significant first; zero past the end
    function automatic logic [7:0] byte_of(input logic [39:0] d, input logic [2:0] len,
                                           input logic [2:0] idx);
        int sh;
        sh = 8 * (int'(len) - 1 - int'(idx));
        if (idx >= len) begin
            return 8'h00;
        end
        return d[sh +: 8]; // [R9]
    endfunction

    assign addr_done = (state == ST_ADDR) && ln.scl_fall && (bit_cnt == BIT_LAST);
    assign rx_done = (state == ST_RX) && ln.scl_fall && (bit_cnt == BIT_LAST);
    assign own_match = (rx_sh[7:1] == own_addr);
    assign ara_match = (rx_sh[7:1] == ARA_ADDR) && rx_sh[0] && alert_pending;
    assign hs_code = (rx_sh[7:3] == HS_CODE_PREFIX);
    assign ara_won = (state == ST_TX) && in_ara && ln.scl_fall && (bit_cnt == BIT_LAST);
    assign tx_next = in_ara ? {own_addr, 1'b0} : byte_of(rd_data, rd_len, tx_idx); // [R13]

    // Result map; values are passed as produced, already two's complement where signed
    always_comb begin
        sel_data = 40'h0000000000;
        sel_len = LEN_WORD;
        case (pointer)
            PTR_BUS_VOLTAGE: sel_data = {24'h000000, BUS_VOLTAGE}; // [R15] [R19]
            PTR_DIE_TEMPERATURE: sel_data = {24'h000000, DIE_TEMPERATURE, TEMP_PAD}; // [R15] [R24]
            PTR_CURRENT: sel_data = {24'h000000, CURRENT}; // [R15] [R17] [R18]
            PTR_POWER: begin
                sel_data = {16'h0000, POWER}; // [R16]
                sel_len = LEN_POWER; // [R24]
            end
            PTR_ENERGY: begin
                sel_data = energy; // [R16]
                sel_len = LEN_ACC; // [R24]
            end
            PTR_CHARGE: begin
                sel_data = charge; // [R16]
                sel_len = LEN_ACC;
            end
            default: begin
                if (pointer < WR_REG_COUNT) begin
                    sel_data = {24'h000000, wr_regs[pointer[2:0]]};
                end
            end
        endcase
    end

    // Protocol engine; SCL is only sampled, never held low
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            rx_sh <= 8'h00;
            tx_sh <= 8'h00;
            rx_idx <= 2'h0;
            tx_idx <= 3'h0;
            is_read <= 1'b0;
            in_ara <= 1'b0;
            sda_oe_n <= 1'b1;
        end else if (ln.stop) begin
            state <= ST_IDLE;
            sda_oe_n <= 1'b1; // [R7]
        end else if (ln.start) begin
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
            in_ara <= 1'b0;
            sda_oe_n <= 1'b1; // [R7]
        end else begin
            case (state)
                ST_ADDR: begin
                    if (ln.scl_rise) begin
                        rx_sh <= {rx_sh[6:0], ln.sda};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    if (addr_done) begin
                        is_read <= rx_sh[0];
                        tx_idx <= 3'h0;
                        if (own_match) begin
                            sda_oe_n <= 1'b0; // [R3]
                            state <= ST_ADDR_ACK;
                        end else if (ara_match) begin
                            in_ara <= 1'b1;
                            sda_oe_n <= 1'b0; // [R13]
                            state <= ST_ADDR_ACK;
                        end else begin
                            state <= ST_WAIT; // [R3] [R11]
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (ln.scl_fall) begin
                        bit_cnt <= 4'h0;
                        rx_idx <= 2'h0;
                        if (is_read) begin
                            tx_sh <= tx_next;
                            sda_oe_n <= tx_next[7];
                            tx_idx <= tx_idx + 3'h1;
                            state <= ST_TX;
                        end else begin
                            sda_oe_n <= 1'b1;
                            state <= ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (ln.scl_rise) begin
                        bit_cnt <= bit_cnt + 4'h1;
                        if (in_ara && sda_oe_n && !ln.sda) begin
                            state <= ST_WAIT; // [R14]
                        end
                    end
                    if (ln.scl_fall) begin
                        if (bit_cnt == BIT_LAST) begin
                            sda_oe_n <= 1'b1;
                            state <= ST_TX_ACK;
                        end else begin
                            tx_sh <= {tx_sh[6:0], 1'b0};
                            sda_oe_n <= tx_sh[6];
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (ln.scl_rise) begin
                        // Alert reply is one byte; a nack ends any read
                        state <= (ln.sda || in_ara) ? ST_WAIT : ST_TX_NEXT; // [R6] [R7]
                    end
                end
                ST_TX_NEXT: begin
                    if (ln.scl_fall) begin
                        tx_sh <= tx_next; // [R6]
                        sda_oe_n <= tx_next[7];
                        tx_idx <= tx_idx + 3'h1;
                        bit_cnt <= 4'h0;
                        state <= ST_TX;
                    end
                end
                ST_RX: begin
                    if (ln.scl_rise) begin
                        rx_sh <= {rx_sh[6:0], ln.sda};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    if (rx_done) begin
                        sda_oe_n <= 1'b0; // [R4]
                        state <= ST_RX_ACK;
                    end
                end
                ST_RX_ACK: begin
                    if (ln.scl_fall) begin
                        sda_oe_n <= 1'b1;
                        bit_cnt <= 4'h0;
                        if (rx_idx != 2'h3) begin
                            rx_idx <= rx_idx + 2'h1;
                        end
                        state <= ST_RX;
                    end
                end
                ST_IDLE, ST_WAIT: begin
                    sda_oe_n <= 1'b1;
                end
                default: begin
                    state <= ST_IDLE;
                    sda_oe_n <= 1'b1;
                end
            endcase
        end
    end

    // Pointer and writable words; only a write moves the pointer
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pointer <= PTR_RESET;
            hi_byte <= 8'h00;
            for (int i = 0; i < 5; i++) begin
                wr_regs[i] <= WR_REG_RESET;
            end
        end else if (rx_done) begin
            case (rx_idx)
                2'h0: pointer <= rx_sh; // [R1] [R2] [R8]
                2'h1: hi_byte <= rx_sh; // [R9]
                2'h2: begin
                    if (pointer < WR_REG_COUNT) begin
                        wr_regs[pointer[2:0]] <= {hi_byte, rx_sh}; // [R4] [R9]
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Snapshot at the read address so multi-byte values stay coherent
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rd_data <= 40'h0000000000;
            rd_len <= LEN_WORD;
        end else if (addr_done && own_match && rx_sh[0]) begin
            rd_data <= sel_data; // [R5]
            rd_len <= sel_len; // [R24]
        end
    end

    // Straps are read at the start and just after the first SCL fall
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            strap_low_start <= 1'b0;
            strap_high_start <= 1'b0;
            first_fall <= 1'b0;
            own_addr <= {TARGET_ADDR_BASE, STRAP_GND, STRAP_GND};
        end else if (ln.start) begin
            strap_low_start <= ADDRESS_STRAP_LOW;
            strap_high_start <= ADDRESS_STRAP_HIGH;
            first_fall <= 1'b1;
        end else if (first_fall && ln.scl_fall) begin
            first_fall <= 1'b0;
            own_addr <= {TARGET_ADDR_BASE, strap_decode(strap_high_start, ADDRESS_STRAP_HIGH),
                         strap_decode(strap_low_start, ADDRESS_STRAP_LOW)}; // [R23]
        end
    end

    // Alert stays pending until our address byte goes out unbroken; pads only pull low
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            alert_d <= 1'b0;
            alert_pending <= 1'b0;
            ALERT_OE_N <= 1'b1;
            SDA_OUT <= 1'b0;
            ALERT_OUT <= 1'b0;
        end else begin
            SDA_OUT <= 1'b0;
            ALERT_OUT <= 1'b0;
            alert_d <= ALERT_ACTIVE;
            if (ALERT_ACTIVE && !alert_d) begin
                alert_pending <= 1'b1;
            end else if (ara_won) begin
                alert_pending <= 1'b0; // [R14]
            end
            ALERT_OE_N <= ~alert_pending; // [R14]
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            hs_mode <= 1'b0;
            HS_MODE <= 1'b0;
        end else begin
            if (ln.stop) begin
                hs_mode <= 1'b0; // [R12]
            end else if (addr_done && hs_code) begin
                hs_mode <= 1'b1; // [R11]
            end
            HS_MODE <= hs_mode;
        end
    end

    assign SDA_OE_N = sda_oe_n; // [R10]
endmodule
`default_nettype wire

// ### tb/ipm_ctrl_model.sv
// Bus controller model: start, stop and byte transfers.
// Assumes a pull-up on SDA; lines change on falling clk only.
`timescale 1ns/10ps
`default_nettype none
module ipm_ctrl_model (
    // Bus
    input wire logic clk,
    input wire logic sda,
    output logic scl = 1'b1,
    output logic sda_drv = 1'b1
);
    // Quarter bit, kept above the slow spike filter width
    localparam int Q = 15;
    task automatic go(input logic c, input logic d);
        repeat (Q) @(negedge clk);
        scl = c;
        sda_drv = d;
    endtask
    // Clock falls before data moves, so no false start or stop
    task automatic bit_io(input logic d, output logic r);
        go(1'b0, sda_drv);
        go(1'b0, d);
        go(1'b1, d);
        repeat (Q) @(negedge clk);
        r = sda;
    endtask
    task automatic start();
        go(1'b0, sda_drv);
        go(1'b0, 1'b1);
        go(1'b1, 1'b1);
        go(1'b1, 1'b0);
    endtask
    task automatic stop();
        go(1'b0, sda_drv);
        go(1'b0, 1'b0);
        go(1'b1, 1'b0);
        go(1'b1, 1'b1);
    endtask
    task automatic tx(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, ack);
    endtask
    task automatic rx(input logic nack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(nack, r);
    endtask
endmodule
`default_nettype wire

// ### tb/ipm_i2c_target_sva.sv
// Checker on the target interface top ports.
// Assumes AVG_SEL stays steady between ticks.
`timescale 1ns/10ps
`default_nettype none
module ipm_i2c_target_sva #(
    parameter int CONV_CYCLES = 20
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Bus
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    input wire logic SDA_OE_N,
    input wire logic HS_MODE,
    // Alert and accumulators
    input wire logic ALERT_ACTIVE,
    input wire logic ALERT_OE_N,
    input wire logic [2:0] AVG_SEL,
    input wire logic CHARGE_OVERFLOW_FLAG,
    input wire logic SAMPLE_TICK
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    a_reset_quiet: assert property ($fell(RST) |-> SDA_OE_N && ALERT_OE_N && !HS_MODE)
        else $error("driving after reset");
    a_drive_scl_low: assert property ($changed(SDA_OE_N) |-> !SCL_IN)
        else $error("sda changed with scl high");
    a_stop_release: assert property (SCL_IN && $rose(SDA_IN) |-> SDA_OE_N [*8])
        else $error("sda held after stop");
    a_hs_no_ack: assert property ($rose(HS_MODE) |-> SDA_OE_N [*8])
        else $error("hs code acknowledged");
    a_hs_stop_exit: assert property (HS_MODE && SCL_IN && $rose(SDA_IN) |-> ##[1:8] !HS_MODE)
        else $error("hs kept after stop");
    a_alert_pull: assert property ($rose(ALERT_ACTIVE) |-> ##[1:8] !ALERT_OE_N)
        else $error("alert not driven");
    int gap;
    always_ff @(posedge CLK) gap <= RST ? 0 : (SAMPLE_TICK ? 1 : gap + 1);
    a_tick_period: assert property (SAMPLE_TICK && AVG_SEL == 3'h0 |-> gap == CONV_CYCLES)
        else $error("tick period wrong");
    a_flag_cause: assert property ($rose(CHARGE_OVERFLOW_FLAG) |-> $past(SAMPLE_TICK))
        else $error("flag without sample");
endmodule
bind ipm_i2c_target ipm_i2c_target_sva #(.CONV_CYCLES(CONV_CYCLES)) ipm_i2c_target_sva_i (
    .CLK, .RST, .SCL_IN, .SDA_IN, .SDA_OE_N, .HS_MODE, .ALERT_ACTIVE, .ALERT_OE_N,
    .AVG_SEL, .CHARGE_OVERFLOW_FLAG, .SAMPLE_TICK);
`default_nettype wire

// ### tb/ipm_i2c_target_tb.sv
// Bench driving the target through the controller model.
// High strap on supply, low strap on ground, so the own address is 44h.
`timescale 1ns/10ps
`default_nettype none
module ipm_i2c_target_tb;
    logic clk = 0, rst = 1, scl, drv, oe_n, so, act = 0, ao, aoe_n, clr = 0, flag, tick, hs, k;
    logic [15:0] bv = 16'h7fff, cur = 16'h8123;
    logic [11:0] tmp = 12'hf38;
    logic [23:0] pw = 24'hc0ffee;
    logic [39:0] v;
    logic [39:0] e [4] = '{40'h7fff, 40'hf380, 40'h8123, 40'hc0ffee};
    int errors = 0, check_count = 0, cyc = 0;
    wire logic sda = drv & (oe_n | so);
    ipm_ctrl_model ipm_ctrl_model_i (.clk(clk), .sda(sda), .scl(scl), .sda_drv(drv));
    ipm_i2c_target #(.CONV_CYCLES(20)) ipm_i2c_target_i (.CLK(clk), .RST(rst), .SCL_IN(scl),
        .SDA_IN(sda), .SDA_OUT(so), .SDA_OE_N(oe_n), .ADDRESS_STRAP_LOW(1'b0),
        .ADDRESS_STRAP_HIGH(1'b1), .ALERT_ACTIVE(act), .ALERT_OUT(ao), .ALERT_OE_N(aoe_n),
        .BUS_VOLTAGE(bv), .DIE_TEMPERATURE(tmp), .CURRENT(cur), .POWER(pw), .AVG_SEL(3'h0),
        .ACCUMULATOR_CLEAR_BIT(clr), .CHARGE_OVERFLOW_FLAG(flag), .SAMPLE_TICK(tick),
        .HS_MODE(hs));
    initial forever #2.5 clk = ~clk;
    task automatic summarize();
        if (errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [39:0] g, input logic [39:0] x);
        check_count++;
        if (g !== x) begin
            errors++;
            $display("unexpected %0t: %h vs %h", $time, g, x);
        end
    endtask
    task automatic tx(input logic [7:0] b, input logic a);
        ipm_ctrl_model_i.tx(b, k);
        chk(k, a);
    endtask
    task automatic wr(input logic [7:0] p);
        ipm_ctrl_model_i.start();
        tx(8'h88, 1'b0);
        tx(p, 1'b0);
    endtask
    task automatic rd(input logic [6:0] a, input int n);
        logic [7:0] b;
        ipm_ctrl_model_i.start();
        tx({a, 1'b1}, 1'b0);
        v = '0;
        for (int i = 1; i <= n; i++) begin
            ipm_ctrl_model_i.rx(i == n, b);
            v = {v[31:0], b};
        end
        ipm_ctrl_model_i.stop();
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk) rst = 0;
        for (int i = 0; i < 4; i++) begin
            wr(8'h05 + 8'(i));
            rd(7'h44, i == 3 ? 3 : 2);
            chk(v, e[i]);
        end
        rd(7'h44, 3);
        chk(v, 40'hc0ffee);
        ipm_ctrl_model_i.start();
        tx(8'h82, 1'b1);
        wr(8'h02);
        tx(8'h5a, 1'b0);
        tx(8'h3c, 1'b0);
        ipm_ctrl_model_i.start();
        tx(8'h09, 1'b1);
        chk(hs, 1'b1);
        rd(7'h44, 2);
        chk(v, 40'h5a3c);
        repeat (8) @(negedge clk);
        chk(hs, 1'b0);
        act = 1;
        repeat (8) @(negedge clk);
        chk({ao, aoe_n}, 2'b00);
        rd(7'h0c, 1);
        chk(v, 40'h88);
        repeat (4) @(negedge clk);
        chk(aoe_n, 1'b1);
        chk(flag, 1'b1);
        clr = 1;
        wr(8'h09);
        rd(7'h44, 5);
        chk(v, 40'h0);
        for (int i = 0; i < 40 && !tick; i++) @(negedge clk);
        repeat (2) @(negedge clk);
        clr = 0;
        chk(flag, 1'b0);
        summarize();
    end
endmodule
`default_nettype wire
